// ===== src/thermal_alert_pkg.sv
// Package for the thermal window alert logic: register offsets, field positions,
// reset values and shared types. Assumes a 32-bit AXI4-Lite register bus.
package thermal_alert_pkg;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_TEMP = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_HYST = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CRIT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_LOW = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_HIGH = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h1c;

  localparam int CFG_SHUTDOWN = 0;
  localparam int CFG_INT_MODE = 1;
  localparam int CFG_CRIT_POL = 2;
  localparam int CFG_INT_POL = 3;
  localparam int CFG_FAULT_Q = 4;
  localparam int CFG_W = 5;

  localparam int TEMP_W = 13;
  localparam int TEMP_LSB = 3;
  localparam logic [TEMP_W-1:0] HYST_RST = 13'h0020;
  localparam logic [TEMP_W-1:0] LOW_RST = 13'h00a0;
  localparam logic [TEMP_W-1:0] HIGH_RST = 13'h0400;
  localparam logic [TEMP_W-1:0] CRIT_RST = 13'h0500;
  localparam logic [CFG_W-1:0] CONFIG_RST = 5'h00;

  localparam int FAULT_COUNT = 4;
  localparam int FQ_W = 3;

  // Sticky event bits: 0 high crossed, 1 low crossed, 2 critical, 3 back in window
  localparam int EV_W = 4;
  localparam int EV_HIGH = 0;
  localparam int EV_LOW = 1;
  localparam int EV_CRIT = 2;
  localparam int EV_INSIDE = 3;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic valid;
    logic signed [TEMP_W-1:0] value;
  } conv_result_t;

  typedef struct packed {
    logic signed [TEMP_W-1:0] low;
    logic signed [TEMP_W-1:0] high;
    logic signed [TEMP_W-1:0] crit;
    logic signed [TEMP_W-1:0] hyst;
  } limits_t;

  typedef struct packed {
    logic crit;
    logic high;
    logic low;
  } flags_t;

endpackage

// ===== src/fault_filter.sv
// Consecutive-fault filter for one limit comparison.
// Assumes sample_en pulses once per completed conversion.
`timescale 1ns/10ps
module fault_filter
  import thermal_alert_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Comparison stream
  input wire logic sample_en,
  input wire logic queue_en,
  input wire logic trip,
  input wire logic clear_cond,
  // Filtered state
  output logic state
);

  logic [FQ_W-1:0] count_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
    end else if (sample_en) begin
      if (!trip) begin
        count_reg <= '0;
      end else if (count_reg < FQ_W'(FAULT_COUNT)) begin
        count_reg <= count_reg + FQ_W'(1);
      end
    end
  end

  // Trips on the conversion that completes the run, or at once with the queue off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= 1'b0;
    end else if (sample_en) begin
      if (trip && (!queue_en || count_reg >= FQ_W'(FAULT_COUNT - 1))) begin
        state <= 1'b1;
      end else if (clear_cond) begin
        state <= 1'b0;
      end
    end
  end

  fault_queue_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
    (sample_en && queue_en && !trip) |=> (count_reg == '0));

  // A queued trip needs the full run of faults behind it
  queue_depth_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
    ($rose(state) && $past(queue_en)) |-> ($past(count_reg) >= FQ_W'(FAULT_COUNT - 1)));

endmodule // fault_filter

// ===== src/thermal_window_alert.sv
// Thermal window alert logic: window and critical comparison, interrupt and alarm.
// Assumes conversion results arrive as one-cycle strobes in aclk's domain.
//
// Contract
// RULE1: Interrupt goes active when temperature leaves the window above high or below low.
// RULE2: Status flags record which limit was exceeded.
// RULE3: In event mode, reprogramming limits to bring temperature inside raises one more interrupt.
// RULE4: In comparator mode the interrupt drops as soon as temperature is back inside; here it drops only once the high or low flag releases past the hysteresis.
// RULE5: In event mode the interrupt stays active until the host reads the device.
// RULE6: A separate critical alarm output follows the critical limit independently.
// RULE7: A fall below the low limit notifies the host and sets the low flag.
// RULE8: Config bit one selects comparator mode at zero and event mode at one.
// RULE9: In event mode any host read clears the interrupt.
// RULE10: Entering shutdown resets both the interrupt and the critical alarm.
// RULE11: With the fault queue on, four consecutive faults are needed before flags or outputs.
// RULE12: Comparisons are evaluated once per completed conversion with the new result.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module thermal_window_alert
  import thermal_alert_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Conversion results
  input wire conv_result_t conv,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Alert pins, open drain; irq is a plain level output
  output logic alert_int_o,
  output logic alert_int_oe,
  output logic critical_alarm_out_o,
  output logic critical_alarm_out_oe,
  output logic irq
);

  logic [CFG_W-1:0] config_reg;
  limits_t limits_reg;
  logic signed [TEMP_W-1:0] temp_reg;
  logic int_reg;
  logic [EV_W-1:0] irq_stat_reg;
  logic [EV_W-1:0] irq_mask_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic limits_written_reg;
  logic shutdown_d_reg;

  logic wr_fire;
  logic rd_fire;
  logic shutdown;
  logic event_mode;
  logic sample_en;
  logic high_trip, low_trip, crit_trip;
  logic high_clr, low_clr, crit_clr;
  logic inside_now;
  flags_t flags;
  logic [EV_W-1:0] ev_pulse;

  assign shutdown = config_reg[CFG_SHUTDOWN];
  assign event_mode = config_reg[CFG_INT_MODE]; // RULE8
  assign sample_en = conv.valid && !shutdown; // RULE12

  // Write channel: address and data taken in either order, response after both
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_reg[1:0] != 2'b00 || awaddr_reg > OFS_IRQ_MASK || awaddr_reg == OFS_TEMP)
        ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; limits take the temperature field from bits 15:3
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_reg <= CONFIG_RST;
      limits_reg <= '{low: LOW_RST, high: HIGH_RST, crit: CRIT_RST, hyst: HYST_RST};
      irq_mask_reg <= '0;
      limits_written_reg <= 1'b0;
    end else begin
      limits_written_reg <= 1'b0;
      if (wr_fire && wstrb_reg[0]) begin
        case (awaddr_reg)
          OFS_CONFIG: config_reg <= wdata_reg[CFG_W-1:0];
          OFS_IRQ_MASK: irq_mask_reg <= wdata_reg[EV_W-1:0];
          default: ;
        endcase
      end
      if (wr_fire && wstrb_reg[1:0] == 2'b11) begin
        limits_written_reg <= 1'b1;
        case (awaddr_reg)
          OFS_HYST: limits_reg.hyst <= wdata_reg[TEMP_LSB +: TEMP_W];
          OFS_CRIT: limits_reg.crit <= wdata_reg[TEMP_LSB +: TEMP_W];
          OFS_LOW: limits_reg.low <= wdata_reg[TEMP_LSB +: TEMP_W];
          OFS_HIGH: limits_reg.high <= wdata_reg[TEMP_LSB +: TEMP_W];
          default: limits_written_reg <= 1'b0;
        endcase
      end
    end
  end

  // Read channel: one read at a time, answer one cycle after the address
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        OFS_TEMP: s_axi_rdata <= {16'h0000, temp_reg, flags.crit, flags.high, flags.low}; // RULE2
        OFS_CONFIG: s_axi_rdata <= {27'h0, config_reg};
        OFS_HYST: s_axi_rdata <= {16'h0000, limits_reg.hyst, 3'b000};
        OFS_CRIT: s_axi_rdata <= {16'h0000, limits_reg.crit, 3'b000};
        OFS_LOW: s_axi_rdata <= {16'h0000, limits_reg.low, 3'b000};
        OFS_HIGH: s_axi_rdata <= {16'h0000, limits_reg.high, 3'b000};
        OFS_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat_reg};
        OFS_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask_reg};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temp_reg <= '0;
    end else if (sample_en) begin
      temp_reg <= conv.value; // RULE12
    end
  end

  // Comparisons; a tripped limit releases only past the hysteresis
  assign high_trip = conv.value > limits_reg.high; // RULE1
  assign low_trip = conv.value < limits_reg.low; // RULE7
  assign crit_trip = conv.value >= limits_reg.crit; // RULE6
  assign high_clr = conv.value <= TEMP_W'(limits_reg.high - limits_reg.hyst);
  assign low_clr = conv.value >= TEMP_W'(limits_reg.low + limits_reg.hyst);
  assign crit_clr = conv.value < TEMP_W'(limits_reg.crit - limits_reg.hyst);

  logic [2:0] trip_vec, clr_vec, state_vec;
  assign trip_vec = {crit_trip, high_trip, low_trip};
  assign clr_vec = {crit_clr, high_clr, low_clr};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_filter
      fault_filter u_filter (
        .aclk(aclk),
        .aresetn(aresetn && !(shutdown && !shutdown_d_reg)),
        .sample_en(sample_en),
        .queue_en(config_reg[CFG_FAULT_Q]), // RULE11
        .trip(trip_vec[gi]),
        .clear_cond(clr_vec[gi]),
        .state(state_vec[gi])
      );
    end
  endgenerate

  assign flags = '{crit: state_vec[2], high: state_vec[1], low: state_vec[0]}; // RULE2
  assign inside_now = !flags.high && !flags.low;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shutdown_d_reg <= 1'b0;
    end else begin
      shutdown_d_reg <= shutdown;
    end
  end

  logic high_d_reg, low_d_reg, crit_d_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_d_reg <= 1'b0;
      low_d_reg <= 1'b0;
      crit_d_reg <= 1'b0;
    end else begin
      high_d_reg <= flags.high;
      low_d_reg <= flags.low;
      crit_d_reg <= flags.crit;
    end
  end

  // Limit rewrite that brings the reading inside: compare stored reading to new limits
  logic reentry;
  assign reentry = limits_written_reg && (high_d_reg || low_d_reg)
    && temp_reg <= limits_reg.high && temp_reg >= limits_reg.low;

  // Event mode: set on crossings and on re-entry, held until any read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_reg <= 1'b0;
    end else if (shutdown && !shutdown_d_reg) begin
      int_reg <= 1'b0; // RULE10
    end else if ((flags.high && !high_d_reg) || (flags.low && !low_d_reg)) begin
      int_reg <= 1'b1; // RULE1 RULE7
    end else if (event_mode && reentry) begin
      int_reg <= 1'b1; // RULE3
    end else if (event_mode && rd_fire) begin
      int_reg <= 1'b0; // RULE5 RULE9
    end else if (!event_mode) begin
      int_reg <= !inside_now; // RULE4
    end
  end

  // Re-entry clears the out flags so comparator mode drops with no new notice
  // is handled by the filters on the next conversion.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert_int_o <= 1'b0;
      alert_int_oe <= 1'b0;
      critical_alarm_out_o <= 1'b0;
      critical_alarm_out_oe <= 1'b0;
    end else begin
      // Open drain: drive low only while the wanted line level is low
      alert_int_o <= 1'b0;
      alert_int_oe <= int_reg ^ config_reg[CFG_INT_POL];
      critical_alarm_out_o <= 1'b0;
      critical_alarm_out_oe <= (flags.crit && !shutdown) ^ config_reg[CFG_CRIT_POL]; // RULE6 RULE10
    end
  end

  assign ev_pulse = {event_mode && reentry, flags.crit && !crit_d_reg,
    flags.low && !low_d_reg, flags.high && !high_d_reg};

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((wr_fire && wstrb_reg[0] && awaddr_reg == OFS_IRQ_STAT)
        ? wdata_reg[EV_W-1:0] : '0)) | ev_pulse;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  int_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (event_mode && int_reg && !rd_fire && !shutdown && $stable(config_reg)) |=> int_reg); // RULE5
  int_readclr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (event_mode && rd_fire && !reentry && $stable(flags) && !(flags.high && !high_d_reg)
      && !(flags.low && !low_d_reg)) |=> !int_reg); // RULE9
  comp_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!event_mode && $stable(config_reg) && inside_now && !shutdown) |=> !int_reg); // RULE4
  high_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (sample_en && !config_reg[CFG_FAULT_Q] && high_trip) |=> flags.high); // RULE1
  low_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (sample_en && !config_reg[CFG_FAULT_Q] && low_trip) |=> flags.low); // RULE7
  crit_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (flags.crit && !shutdown && !config_reg[CFG_CRIT_POL]) |=> critical_alarm_out_oe == 1'b1); // RULE6
  shutdown_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (shutdown && !shutdown_d_reg) |=> !int_reg); // RULE10
  reentry_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (event_mode && reentry && !(shutdown && !shutdown_d_reg)) |=> int_reg); // RULE3
  sample_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!sample_en) |=> $stable(temp_reg)); // RULE12
  queue_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (config_reg[CFG_FAULT_Q] && $rose(flags.high)) |-> $past(sample_en)); // RULE11
  mode_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!config_reg[CFG_INT_MODE] && !shutdown && !inside_now) |=> int_reg); // RULE8

  // Shutdown entry: flags and interrupt drop at once, pins go idle one edge apart
  sequence shut_enter_s;
    shutdown && !shutdown_d_reg;
  endsequence

  sequence shut_quiet_s;
    (!int_reg && flags == '0 && critical_alarm_out_oe == $past(config_reg[CFG_CRIT_POL]))
      ##1 (alert_int_oe == $past(config_reg[CFG_INT_POL]));
  endsequence

  shutdown_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
    shut_enter_s |=> shut_quiet_s);

  // Critical path: conversion, flag, then pin, whatever the window does
  sequence crit_sample_s;
    sample_en && !config_reg[CFG_FAULT_Q] && crit_trip;
  endsequence

  sequence crit_drive_s;
    flags.crit ##1 ($past(shutdown) || critical_alarm_out_oe == !$past(config_reg[CFG_CRIT_POL]));
  endsequence

  crit_chain_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
    crit_sample_s |=> crit_drive_s);

endmodule // thermal_window_alert

// ===== test/sensor_side_model.sv
// Far-side model: conversion engine strobing results, and the pulled-up alert lines.
// Assumes go pulses for one aclk cycle per requested conversion.
`timescale 1ns/10ps
module sensor_side_model
  import thermal_alert_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Conversion request
  input wire logic go,
  input wire logic [TEMP_W-1:0] temp,
  output conv_result_t conv,
  // Open-drain lines
  input wire logic int_oe,
  input wire logic crit_oe,
  output logic int_pin,
  output logic crit_pin
);
  // Value scrambled outside a strobe so no stale reading looks valid
  always_ff @(posedge aclk) begin
    conv.valid <= go;
    conv.value <= go ? temp : ~temp;
  end
  // External pull-ups
  assign int_pin = int_oe ? 1'b0 : 1'b1;
  assign crit_pin = crit_oe ? 1'b0 : 1'b1;
endmodule // sensor_side_model

// ===== test/tb_top.sv
// Self-checking bench for the thermal window alert logic.
// Assumes the sensor_side_model drives conversions and pulls the alert lines up.
`timescale 1ns/10ps
module tb_top
  import thermal_alert_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, int_o, int_oe, crit_o, crit_oe, irq, int_pin, crit_pin;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd_v;
  conv_result_t conv;
  logic go = 1'b0;
  logic [12:0] temp = 13'h0, t;
  int fail_count = 0;
  int checked = 0;
  int k;

  always #4 aclk = ~aclk;

  thermal_window_alert thermal_window_alert_i (.aclk(aclk), .aresetn(aresetn), .conv(conv),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .alert_int_o(int_o), .alert_int_oe(int_oe), .critical_alarm_out_o(crit_o),
    .critical_alarm_out_oe(crit_oe), .irq(irq));

  sensor_side_model sensor_side_model_i (.aclk(aclk), .go(go), .temp(temp), .conv(conv),
    .int_oe(int_oe), .crit_oe(crit_oe), .int_pin(int_pin), .crit_pin(crit_pin));

  function automatic logic [31:0] lim(input logic [12:0] v);
    return {16'h0000, v, 3'b000};
  endfunction

  function automatic logic win_out(input logic signed [12:0] v, input logic signed [12:0] lo,
    input logic signed [12:0] hi);
    return (v > hi) || (v < lo);
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic timeout();
    fail_count++;
    $display("[ERR] %0t bus wait ran out", $time);
    test_done();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
      if (n > 50) timeout();
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
      if (n > 50) timeout();
    end while (!rvalid);
    rd_v = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_v, exp);
  endtask

  // Strobe lands, flags one edge later, crit pin one more, int pin two more: five edges cover it
  task automatic conv_do(input logic [12:0] v);
    @(posedge aclk);
    temp <= v;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    cyc(5);
  endtask

  task automatic pins(input logic int_act, input logic crit_act);
    chk(32'(int_pin), 32'(!int_act));
    chk(32'(crit_pin), 32'(!crit_act));
    chk(32'({int_o, crit_o}), 32'h0);
  endtask

  initial begin
    void'($urandom(32'hdfe5f5a0));
    cyc(2);
    aresetn <= 1'b1;
    rdc(OFS_CONFIG, 32'h0);
    rdc(OFS_HYST, lim(HYST_RST));
    rdc(OFS_LOW, lim(LOW_RST));
    rdc(OFS_HIGH, lim(HIGH_RST));
    rdc(OFS_CRIT, lim(CRIT_RST));
    rd(8'h40);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(OFS_TEMP, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    // Comparator mode, both window edges, status and irq path
    wr(OFS_IRQ_MASK, 32'h3);
    conv_do(13'h0401);
    pins(1'b1, 1'b0);
    rdc(OFS_TEMP, lim(13'h0401) | 32'h2);
    chk(32'(irq), 32'h1);
    wr(OFS_IRQ_STAT, 32'h1);
    cyc(2);
    chk(32'(irq), 32'h0);
    conv_do(13'h0300);
    pins(1'b0, 1'b0);
    conv_do(13'h0050);
    pins(1'b1, 1'b0);
    rdc(OFS_TEMP, lim(13'h0050) | 32'h1);
    chk(32'(irq), 32'h1);
    wr(OFS_IRQ_STAT, 32'h2);
    conv_do(13'h0300);
    pins(1'b0, 1'b0);
    // Event mode: held until read, then one more after reprogramming
    wr(OFS_CONFIG, 32'h2);
    conv_do(13'h0401);
    cyc(8);
    pins(1'b1, 1'b0);
    rd(OFS_CONFIG);
    cyc(2);
    pins(1'b0, 1'b0);
    wr(OFS_HIGH, lim(13'h0480));
    cyc(3);
    pins(1'b1, 1'b0);
    rd(OFS_TEMP);
    cyc(2);
    pins(1'b0, 1'b0);
    wr(OFS_HIGH, lim(13'h0400));
    conv_do(13'h0300);
    rd(OFS_TEMP);
    rdc(OFS_IRQ_STAT, 32'h9);
    wr(OFS_IRQ_STAT, 32'hf);
    // Critical alarm apart from the window, then shutdown
    wr(OFS_CONFIG, 32'h0);
    wr(OFS_HIGH, lim(13'h0600));
    conv_do(13'h0500);
    pins(1'b0, 1'b1);
    rdc(OFS_TEMP, lim(13'h0500) | 32'h4);
    wr(OFS_HIGH, lim(13'h0400));
    conv_do(13'h0500);
    pins(1'b1, 1'b1);
    wr(OFS_CONFIG, 32'h1);
    cyc(3);
    pins(1'b0, 1'b0);
    wr(OFS_CONFIG, 32'h0);
    conv_do(13'h0300);
    // Fault queue: fourth consecutive fault trips
    wr(OFS_CONFIG, 32'h10);
    repeat (3) conv_do(13'h0401);
    pins(1'b0, 1'b0);
    rdc(OFS_TEMP, lim(13'h0401));
    conv_do(13'h0401);
    pins(1'b1, 1'b0);
    repeat (4) conv_do(13'h0300);
    // Active-high polarity on both lines: released pin means active
    wr(OFS_CONFIG, 32'hc);
    conv_do(13'h0501);
    chk(32'({int_pin, crit_pin}), 32'h3);
    conv_do(13'h0300);
    chk(32'({int_pin, crit_pin}), 32'h0);
    wr(OFS_CONFIG, 32'h0);
    // Random readings kept clear of the hysteresis bands
    for (int i = 0; i < 12; i++) begin
      k = $urandom % 3;
      if (k == 0) t = 13'(13'h0401 + $urandom % 13'h00f0);
      else if (k == 1) t = 13'(13'h0020 + $urandom % 13'h0070);
      else t = 13'(13'h00c0 + $urandom % 13'h0300);
      conv_do(t);
      pins(win_out(t, LOW_RST, HIGH_RST), 1'b0);
    end
    test_done();
  end
endmodule // tb_top
